// ==== core/uart_dma_serial_port.sv ====
// Purpose: serial transmitter/receiver with one dma channel per direction
// Assumes: rxd synchronous to clk; memory answers with memAck pulse
// Notes:   no character queue, one holding register per direction
// Function
// - no queue; characters moved one at a time
// - two channels: 32-bit address, 16-bit count
// - rx address is destination, tx is source
// - count drops by one; zero signals done
// - done raises interrupt only when enabled
// - falling edge on idle line starts character
// - sixteen ticks per bit, sample seventh
// - start, data lsb first, parity, stop
// - data length field picks data bits
// - parity even xor, odd inverted xor
// - stop bit field sets stop count
// - zero gap: next character immediately
// - nonzero gap: line high that many bits
// - holding empty flag when holding register empties
// - shifter empty flag when shifter finishes
// - tx done flag and code after last load
// - two characters still pending at tx done
// - rx done flag and code after last store
// - receive line idle at rx done
// - bit rate is clock over 32 times divisor
// - fraction accumulator stretches divisor on overflow
// - line errors raise line status interrupt
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`include "uart_dma_map.svh"

module uart_dma_serial_port (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [7:0]            regAddr,
   input  wire logic [31:0]           regWdata,
   input  wire logic                  regWr,
   input  wire logic                  regRd,
   output      logic [31:0]           regRdata,
   input  wire logic                  rxd,
   output      logic                  txd,
   output      logic                  irq,
   output      uart_dma_pkg::mem_req_t mem,
   input  wire logic                  memAck,
   input  wire logic [7:0]            memRdata
);
   import uart_dma_pkg::*;

   // ***********************************************************
   // declarations
   // ***********************************************************
   logic [5:0]  irqEnable_reg;
   line_ctl_t   lineCtl_reg;
   logic [15:0] baudDiv_reg;
   logic [7:0]  baudFrac_reg;
   logic [7:0]  gap_reg;
   logic [1:0]  dmaEn_reg;
   logic        dtxDone_reg, drxDone_reg;
   logic [31:0] txAddr_reg, rxAddr_reg;
   logic [15:0] txCount_reg, rxCount_reg;
   dma_state_t  dma_reg;
   logic [17:0] baudCnt_reg;
   logic [7:0]  fracAcc_reg;
   logic        tick_reg;
   logic [7:0]  txHold_reg;
   logic        txHoldEmpty_reg;
   tx_state_t   tx_reg;
   logic [7:0]  txShift_reg;
   logic [3:0]  txTick_reg;
   logic [2:0]  txBit_reg;
   logic [7:0]  txGapCnt_reg;
   logic        txParity_reg;
   rx_state_t   rx_reg;
   logic        rxPrev_reg;
   logic [3:0]  rxTick_reg;
   logic [2:0]  rxBit_reg;
   logic [7:0]  rxShift_reg;
   logic        rxParity_reg;
   logic [7:0]  rxHold_reg;
   logic        dataReady_reg, overrun_reg;
   logic        parityErr_reg, framingErr_reg, break_reg;
   logic [3:0]  irqId_reg;

   logic        wrData, rdData, rdLineSts;
   logic [2:0]  lastBit;
   logic        txShiftEmpty, txBitEnd, txLoad, rxDone, rxSample;
   logic        dmaTxAck, dmaRxAck, rxStopOk;

   // number of data bits minus one, from the length field
   function automatic logic [2:0] lastIndex(input logic [1:0] sel);
      lastIndex = 3'(`MIN_DATA_BITS - 4'h1 + {2'b00, sel});
   endfunction

   // parity over the active data bits; odd inverts
   function automatic logic parityOf(input logic [7:0] d,
                                     input logic [1:0] sel,
                                     input logic       even);
      logic [7:0] mask;
      mask = 8'hFF >> (3'd3 - {1'b0, sel});
      parityOf = (^(d & mask)) ^ ~even;
   endfunction

   // ***********************************************************
   // register port decode
   // ***********************************************************
   assign wrData    = regWr && regAddr == `OFS_DATA;
   assign rdData    = regRd && regAddr == `OFS_DATA;
   assign rdLineSts = regRd && regAddr == `OFS_LINE_STS;
   assign lastBit   = lastIndex(lineCtl_reg.dataLengthSel);
   assign dmaTxAck  = dma_reg == DMA_TX_RD && memAck;
   assign dmaRxAck  = dma_reg == DMA_RX_WR && memAck;

   // configuration registers written by software
   always_ff @(posedge clk) begin
      if (rst) begin
         irqEnable_reg <= 6'h00;
         lineCtl_reg   <= `RST_LINE_CTL;
         baudDiv_reg   <= `RST_BAUD_DIV;
         baudFrac_reg  <= 8'h00;
         gap_reg       <= 8'h00;
      end else if (regWr) begin
         unique case (regAddr)
            `OFS_IRQ_EN:    irqEnable_reg <= regWdata[5:0];
            `OFS_LINE_CTL:  lineCtl_reg   <= regWdata[4:0];
            `OFS_BAUD_DIV:  baudDiv_reg   <= regWdata[15:0];
            `OFS_BAUD_FRAC: baudFrac_reg  <= regWdata[7:0];
            `OFS_GAP:       gap_reg       <= regWdata[7:0];
            default: ;
         endcase
      end
   end

   // read data registered, valid the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         regRdata <= 32'h0000_0000;
      end else if (regRd) begin
         unique case (regAddr)
            `OFS_DATA:      regRdata <= {24'h0, rxHold_reg};
            `OFS_IRQ_EN:    regRdata <= {26'h0, irqEnable_reg};
            `OFS_IRQ_ID:    regRdata <= {28'h0, irqId_reg};
            `OFS_LINE_CTL:  regRdata <= {27'h0, lineCtl_reg};
            `OFS_LINE_STS:  regRdata <= {25'h0, txShiftEmpty,
                               txHoldEmpty_reg, break_reg, framingErr_reg,
                               parityErr_reg, overrun_reg, dataReady_reg};
            `OFS_BAUD_DIV:  regRdata <= {16'h0, baudDiv_reg};
            `OFS_BAUD_FRAC: regRdata <= {24'h0, baudFrac_reg};
            `OFS_GAP:       regRdata <= {24'h0, gap_reg};
            `OFS_DMA_CTL:   regRdata <= {22'h0, drxDone_reg, dtxDone_reg,
                                         6'h0, dmaEn_reg};
            `OFS_TX_ADDR:   regRdata <= txAddr_reg;
            `OFS_TX_COUNT:  regRdata <= {16'h0, txCount_reg};
            `OFS_RX_ADDR:   regRdata <= rxAddr_reg;
            `OFS_RX_COUNT:  regRdata <= {16'h0, rxCount_reg};
            default:        regRdata <= 32'h0000_0000;
         endcase
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end

   // ***********************************************************
   // baud tick generator, 16 ticks per bit
   // ***********************************************************
   // tick period is 2*divisor clocks, so a bit is 32*divisor clocks;
   // divisor 0 is treated as 1 to keep the counter alive
   always_ff @(posedge clk) begin
      if (rst) begin
         baudCnt_reg <= 18'h00000;
         fracAcc_reg <= 8'h00;
         tick_reg    <= 1'b0;
      end else if (baudCnt_reg == 18'h00000) begin
         tick_reg    <= 1'b1;
         fracAcc_reg <= fracAcc_reg + baudFrac_reg;
         baudCnt_reg <= {1'b0, (baudDiv_reg == 16'h0000) ? 16'h0001
                        : baudDiv_reg, 1'b0} - 18'h00001
                        + ((baudFrac_reg != 8'h00 &&
                            {1'b0, fracAcc_reg} + {1'b0, baudFrac_reg}
                            > 9'h0FF) ? 18'h00002 : 18'h00000);
      end else begin
         tick_reg    <= 1'b0;
         baudCnt_reg <= baudCnt_reg - 18'h00001;
      end
   end

   // ***********************************************************
   // transmitter
   // ***********************************************************
   assign txShiftEmpty = tx_reg == TX_IDLE;
   assign txBitEnd     = tick_reg && txTick_reg == `TICKS_PER_BIT;
   // zero gap lets the next start bit follow the stop bit directly
   assign txLoad = !txHoldEmpty_reg && (tx_reg == TX_IDLE ||
                   (tx_reg == TX_STOP && txBitEnd && txBit_reg[0] ==
                    lineCtl_reg.stopBitCountSel && gap_reg == 8'h00));

   // holding register: software or tx channel fills, shifter drains
   always_ff @(posedge clk) begin
      if (rst) begin
         txHold_reg      <= 8'h00;
         txHoldEmpty_reg <= 1'b1;
      end else if (wrData || dmaTxAck) begin
         txHold_reg      <= wrData ? regWdata[7:0] : memRdata;
         txHoldEmpty_reg <= 1'b0;
      end else if (txLoad) begin
         txHoldEmpty_reg <= 1'b1;
      end
   end

   // shifter state machine, bits change on tick boundaries
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_reg       <= TX_IDLE;
         txd          <= 1'b1;
         txShift_reg  <= 8'h00;
         txTick_reg   <= 4'h0;
         txBit_reg    <= 3'h0;
         txGapCnt_reg <= 8'h00;
         txParity_reg <= 1'b0;
      end else if (txLoad) begin
         tx_reg       <= TX_START;
         txd          <= 1'b0;
         txShift_reg  <= txHold_reg;
         txParity_reg <= parityOf(txHold_reg, lineCtl_reg.dataLengthSel,
                                  lineCtl_reg.parityEven);
         txTick_reg   <= 4'h0;
         txBit_reg    <= 3'h0;
      end else if (tick_reg && tx_reg != TX_IDLE) begin
         txTick_reg <= txTick_reg + 4'h1;
         if (txTick_reg == `TICKS_PER_BIT) begin
            unique case (tx_reg)
               TX_START: begin
                  tx_reg      <= TX_DATA;
                  txd         <= txShift_reg[0]; // lsb first
                  txShift_reg <= txShift_reg >> 1;
               end
               TX_DATA: begin
                  txBit_reg <= txBit_reg + 3'h1;
                  if (txBit_reg == lastBit) begin
                     txBit_reg <= 3'h0;
                     tx_reg    <= lineCtl_reg.parityEnableBit ? TX_PAR
                                  : TX_STOP;
                     txd       <= lineCtl_reg.parityEnableBit ?
                                  txParity_reg : 1'b1;
                  end else begin
                     txd         <= txShift_reg[0];
                     txShift_reg <= txShift_reg >> 1;
                  end
               end
               TX_PAR: begin
                  tx_reg <= TX_STOP;
                  txd    <= 1'b1;
               end
               TX_STOP: begin
                  txBit_reg <= txBit_reg + 3'h1;
                  if (txBit_reg[0] == lineCtl_reg.stopBitCountSel) begin
                     txGapCnt_reg <= gap_reg;
                     tx_reg <= (gap_reg == 8'h00) ? TX_IDLE : TX_GAP;
                  end
               end
               TX_GAP: begin
                  // line stays high for the programmed bit periods
                  txGapCnt_reg <= txGapCnt_reg - 8'h01;
                  if (txGapCnt_reg == 8'h01) begin
                     tx_reg <= TX_IDLE;
                  end
               end
               default: tx_reg <= TX_IDLE;
            endcase
         end
      end
   end

   // ***********************************************************
   // receiver
   // ***********************************************************
   assign rxSample = tick_reg && rxTick_reg == `SAMPLE_TICK;
   assign rxDone   = rx_reg == RX_STOP && rxSample;
   assign rxStopOk = rxd;

   // character framing; the stop bit ends at its own sample point
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_reg       <= RX_IDLE;
         rxPrev_reg   <= 1'b1;
         rxTick_reg   <= 4'h0;
         rxBit_reg    <= 3'h0;
         rxShift_reg  <= 8'h00;
         rxParity_reg <= 1'b0;
      end else begin
         rxPrev_reg <= rxd;
         if (rx_reg == RX_IDLE) begin
            if (rxPrev_reg && !rxd) begin
               rx_reg      <= RX_START;
               rxTick_reg  <= 4'h0;
               rxBit_reg   <= 3'h0;
               rxShift_reg <= 8'h00;
            end
         end else if (tick_reg) begin
            rxTick_reg <= rxTick_reg + 4'h1;
            unique case (rx_reg)
               RX_START: begin
                  // a glitch that is high again is not a start bit
                  if (rxSample && rxd) begin
                     rx_reg <= RX_IDLE;
                  end else if (rxTick_reg == `TICKS_PER_BIT) begin
                     rx_reg <= RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (rxSample) begin
                     rxShift_reg[rxBit_reg] <= rxd;
                  end
                  if (rxTick_reg == `TICKS_PER_BIT) begin
                     rxBit_reg <= rxBit_reg + 3'h1;
                     if (rxBit_reg == lastBit) begin
                        rx_reg <= lineCtl_reg.parityEnableBit ? RX_PAR
                                  : RX_STOP;
                     end
                  end
               end
               RX_PAR: begin
                  if (rxSample) begin
                     rxParity_reg <= rxd;
                  end
                  if (rxTick_reg == `TICKS_PER_BIT) begin
                     rx_reg <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  if (rxSample) begin
                     rx_reg <= RX_IDLE;
                  end
               end
               default: rx_reg <= RX_IDLE;
            endcase
         end
      end
   end

   // received character and line status; a new event beats a clear
   always_ff @(posedge clk) begin
      if (rst) begin
         rxHold_reg     <= 8'h00;
         dataReady_reg  <= 1'b0;
         overrun_reg    <= 1'b0;
         parityErr_reg  <= 1'b0;
         framingErr_reg <= 1'b0;
         break_reg      <= 1'b0;
      end else begin
         if (rxDone) begin
            rxHold_reg    <= rxShift_reg;
            dataReady_reg <= 1'b1;
         end else if (rdData || dmaRxAck) begin
            dataReady_reg <= 1'b0;
         end
         if (rxDone && dataReady_reg && !(rdData || dmaRxAck)) begin
            overrun_reg <= 1'b1;
         end else if (rdLineSts) begin
            overrun_reg <= 1'b0;
         end
         if (rxDone && lineCtl_reg.parityEnableBit &&
             rxParity_reg != parityOf(rxShift_reg,
                lineCtl_reg.dataLengthSel, lineCtl_reg.parityEven)) begin
            parityErr_reg <= 1'b1;
         end else if (rdLineSts) begin
            parityErr_reg <= 1'b0;
         end
         if (rxDone && !rxStopOk) begin
            framingErr_reg <= 1'b1;
         end else if (rdLineSts) begin
            framingErr_reg <= 1'b0;
         end
         // break: whole character including stop held low
         if (rxDone && !rxStopOk && rxShift_reg == 8'h00 &&
             !(lineCtl_reg.parityEnableBit && rxParity_reg)) begin
            break_reg <= 1'b1;
         end else if (rdLineSts) begin
            break_reg <= 1'b0;
         end
      end
   end

   // ***********************************************************
   // dma channels
   // ***********************************************************
   // one memory port shared; transmit is served first. done flags
   // are cleared by writing one, and a new done wins over the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         dma_reg     <= DMA_IDLE;
         mem         <= '0;
         dmaEn_reg   <= 2'b00;
         dtxDone_reg <= 1'b0;
         drxDone_reg <= 1'b0;
         txAddr_reg  <= 32'h0000_0000;
         rxAddr_reg  <= 32'h0000_0000;
         txCount_reg <= 16'h0000;
         rxCount_reg <= 16'h0000;
      end else begin
         if (regWr) begin
            unique case (regAddr)
               `OFS_DMA_CTL: begin
                  dmaEn_reg <= regWdata[1:0];
                  if (regWdata[`DMA_DTX]) dtxDone_reg <= 1'b0;
                  if (regWdata[`DMA_DRX]) drxDone_reg <= 1'b0;
               end
               `OFS_TX_ADDR:  txAddr_reg  <= regWdata;
               `OFS_TX_COUNT: txCount_reg <= regWdata[15:0];
               `OFS_RX_ADDR:  rxAddr_reg  <= regWdata;
               `OFS_RX_COUNT: rxCount_reg <= regWdata[15:0];
               default: ;
            endcase
         end
         unique case (dma_reg)
            DMA_IDLE: begin
               if (dmaEn_reg[`DMA_TXEN] && txCount_reg != 16'h0000 &&
                   txHoldEmpty_reg && !wrData) begin
                  dma_reg <= DMA_TX_RD;
                  mem     <= '{req: 1'b1, write: 1'b0, addr: txAddr_reg,
                               wdata: 8'h00};
               end else if (dmaEn_reg[`DMA_RXEN] &&
                            rxCount_reg != 16'h0000 && dataReady_reg &&
                            !rdData) begin
                  dma_reg <= DMA_RX_WR;
                  mem     <= '{req: 1'b1, write: 1'b1, addr: rxAddr_reg,
                               wdata: rxHold_reg};
               end
            end
            DMA_TX_RD: begin
               if (memAck) begin
                  dma_reg     <= DMA_IDLE;
                  mem         <= '0;
                  txAddr_reg  <= txAddr_reg + 32'h0000_0001;
                  txCount_reg <= txCount_reg - 16'h0001;
                  // holding and shifter still carry data here
                  if (txCount_reg == 16'h0001) begin
                     dtxDone_reg <= 1'b1;
                  end
               end
            end
            DMA_RX_WR: begin
               if (memAck) begin
                  dma_reg     <= DMA_IDLE;
                  mem         <= '0;
                  rxAddr_reg  <= rxAddr_reg + 32'h0000_0001;
                  rxCount_reg <= rxCount_reg - 16'h0001;
                  // the stop bit has been sampled, line is idle
                  if (rxCount_reg == 16'h0001) begin
                     drxDone_reg <= 1'b1;
                  end
               end
            end
            default: dma_reg <= DMA_IDLE;
         endcase
      end
   end

   // ***********************************************************
   // interrupt identification, highest priority first
   // ***********************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         irqId_reg <= `IID_NONE;
         irq       <= 1'b0;
      end else begin
         irq <= 1'b1;
         if (irqEnable_reg[`IEN_RLS] && (overrun_reg || parityErr_reg ||
             framingErr_reg || break_reg)) begin
            irqId_reg <= `IID_RLS;
         end else if (irqEnable_reg[`IEN_RXD] && dataReady_reg) begin
            irqId_reg <= `IID_RXD;
         end else if (irqEnable_reg[`IEN_DRX] && drxDone_reg) begin
            irqId_reg <= `IID_DRX;
         end else if (irqEnable_reg[`IEN_DTX] && dtxDone_reg) begin
            irqId_reg <= `IID_DTX;
         end else if (irqEnable_reg[`IEN_TX_HOLD_EMPTY_FLAG] && txHoldEmpty_reg) begin
            irqId_reg <= `IID_TX_HOLD_EMPTY_FLAG;
         end else if (irqEnable_reg[`IEN_TXE] && txShiftEmpty &&
                      txHoldEmpty_reg) begin
            irqId_reg <= `IID_TXE;
         end else begin
            irqId_reg <= `IID_NONE;
            irq       <= 1'b0;
         end
      end
   end
endmodule

// ==== core/uart_dma_map.svh ====
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: word-aligned 8-bit register offsets
// Notes:   definitions only
`ifndef UART_DMA_MAP_SVH
`define UART_DMA_MAP_SVH

// ***********************************************************
// register offsets
// ***********************************************************
`define OFS_DATA      8'h00
`define OFS_IRQ_EN    8'h04
`define OFS_IRQ_ID    8'h08
`define OFS_LINE_CTL  8'h0C
`define OFS_LINE_STS  8'h10
`define OFS_BAUD_DIV  8'h14
`define OFS_BAUD_FRAC 8'h18
`define OFS_GAP       8'h1C
`define OFS_DMA_CTL   8'h20
`define OFS_TX_ADDR   8'h24
`define OFS_TX_COUNT  8'h28
`define OFS_RX_ADDR   8'h2C
`define OFS_RX_COUNT  8'h30

// ***********************************************************
// field positions
// ***********************************************************
`define IEN_RXD   0
`define IEN_TX_HOLD_EMPTY_FLAG  1
`define IEN_RLS   2
`define IEN_TXE   3
`define IEN_DTX   4
`define IEN_DRX   5
`define DMA_TXEN  0
`define DMA_RXEN  1
`define DMA_DTX   8
`define DMA_DRX   9

// ***********************************************************
// interrupt identification codes and reset values
// ***********************************************************
`define IID_NONE  4'h1
`define IID_RLS   4'h6
`define IID_RXD   4'h4
`define IID_DRX   4'hC
`define IID_DTX   4'hA
`define IID_TX_HOLD_EMPTY_FLAG  4'h2
`define IID_TXE   4'hE
`define RST_LINE_CTL 5'h03
`define RST_BAUD_DIV 16'h0000

// ***********************************************************
// timing counts
// ***********************************************************
`define TICKS_PER_BIT 4'hF
`define SAMPLE_TICK   4'h6
`define MIN_DATA_BITS 4'h5

`endif

// ==== core/uart_dma_pkg.sv ====
// Purpose: shared types of the serial port
// Assumes: nothing
// Notes:   constants live in uart_dma_map.svh
package uart_dma_pkg;
   // line control fields
   typedef struct packed {
      logic       parityEven;
      logic       parityEnableBit;
      logic       stopBitCountSel;
      logic [1:0] dataLengthSel;
   } line_ctl_t;

   // memory side of the dma channels
   typedef struct packed {
      logic        req;
      logic        write;
      logic [31:0] addr;
      logic [7:0]  wdata;
   } mem_req_t;

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
                             RX_STOP} rx_state_t;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP,
                             TX_GAP} tx_state_t;
   typedef enum logic [1:0] {DMA_IDLE, DMA_TX_RD, DMA_RX_WR} dma_state_t;
endpackage

// ==== verification/uart_dma_checker.sv ====
// Purpose: port assertions of the serial port
// Assumes: baud divisor at least one, so a bit lasts 30+ clocks
// Notes:   bound to the design at the foot of this file
module uart_dma_checker (
   input logic                   clk,
   input logic                   rst,
   input logic [7:0]             regAddr,
   input logic [31:0]            regWdata,
   input logic                   regWr,
   input logic                   regRd,
   input logic [31:0]            regRdata,
   input logic                   txd,
   input logic                   irq,
   input uart_dma_pkg::mem_req_t mem,
   input logic                   memAck
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // reset leaves line idle, irq and memory request quiet
   property p_rst; disable iff (1'b0) rst |=> txd && !irq && !mem.req;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_rdIdle; !regRd |=> regRdata == 32'h0; endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data not 0");
   property p_unmapped; regRd && regAddr == 8'hFC |=> regRdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   // request held unchanged until acknowledged
   property p_hold; mem.req && !memAck |=> $stable(mem); endproperty
   a_hold: assert property (p_hold) else $error("request moved");
   property p_drop; mem.req && memAck |=> !mem.req; endproperty
   a_drop: assert property (p_drop) else $error("request kept");
   // no bit on the line is shorter than nine clocks
   property p_low; $fell(txd) |=> !txd [*8]; endproperty
   a_low: assert property (p_low) else $error("low bit short");
   property p_high; $rose(txd) |=> txd [*8]; endproperty
   a_high: assert property (p_high) else $error("high bit cut");
   property p_mask;
      regWr && regAddr == 8'h04 && regWdata[5:0] == 6'h00 |-> ##[1:3] !irq;
   endproperty
   a_mask: assert property (p_mask) else $error("irq not masked");
endmodule

bind uart_dma_serial_port uart_dma_checker uart_dma_checker_inst (.clk,
   .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .txd, .irq, .mem,
   .memAck);

// ==== verification/remote_uart.sv ====
// Purpose: far serial device on the line pins
// Assumes: divisor one and no fraction, so a bit is 32 clocks
// Notes:   line idles high between frames
module remote_uart (
   input  logic clk,
   input  logic txLine,
   output logic rxLine
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BitClk = 32;
   initial rxLine = 1'b1;
   // sample n bits at mid-bit from the falling start edge
   task automatic grab(input int n, output logic [11:0] bits);
      bits = '0;
      @(negedge txLine);
      for (int i = 0; i < n; i++) begin
         repeat (i ? BitClk : BitClk / 2) @(posedge clk);
         bits[i] = txLine;
      end
   endtask
   // one 8N1 frame, start low, lsb first, stop high
   task automatic send(input logic [7:0] d);
      for (int i = 0; i < 10; i++) begin
         rxLine <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i - 1];
         repeat (BitClk) @(posedge clk);
      end
   endtask
endmodule

// ==== verification/tb_uart_dma_serial_port.sv ====
// Purpose: self-checking bench of the serial port
// Assumes: divisor one; memory answers after random latency
// Notes:   random data from an lfsr with a fixed start
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin numErrors++; \
   $display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
module tb_uart_dma_serial_port;
   timeunit 1ns;
   timeprecision 1ps;
   import uart_dma_pkg::*;
   logic clk = 0, rst = 1, regWr = 0, regRd = 0, memAck = 0, txd, irq, rxd;
   logic [7:0]  regAddr = 0, memRdata = 0, d, wq[$];
   logic [31:0] regWdata = 0, regRdata, v, lfsrReg = 32'h2CF0CA10, aq[$];
   logic [11:0] g, e, m;
   logic [4:0]  lc;
   mem_req_t    mem;
   int numErrors = 0, checksDone = 0, cyc = 0, n;
   uart_dma_serial_port uart_dma_serial_port_inst (.clk, .rst, .regAddr,
      .regWdata, .regWr, .regRd, .regRdata, .rxd, .txd, .irq, .mem, .memAck,
      .memRdata);
   remote_uart remote_uart_inst (.clk, .txLine(txd), .rxLine(rxd));
   initial forever #12.5 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected line bits: start, data, parity, stops, idle high above
   function automatic logic [11:0] frame(input logic [7:0] dd,
                                         input logic [4:0] c, output int k);
      logic [11:0] f;
      int nb;
      nb = 5 + c[1:0];
      f = '1;
      f[0] = 1'b0;
      for (int i = 0; i < nb; i++) f[i + 1] = dd[i];
      if (c[3]) f[nb + 1] = ^(dd & ((8'h1 << nb) - 8'h1)) ^ ~c[4];
      k = nb + 2 + c[2] + c[3];
      return f;
   endfunction
   // memory: random latency, reads return address xor 5A
   always @(posedge clk) begin
      lfsrReg  <= lfsr(lfsrReg);
      cyc      <= cyc + 1;
      memAck   <= mem.req && !memAck && lfsrReg[0];
      memRdata <= mem.addr[7:0] ^ 8'h5A;
      if (mem.req && memAck && mem.write) wq.push_back(mem.wdata);
      if (mem.req && memAck && mem.write) aq.push_back(mem.addr);
      if (cyc == 40000) begin numErrors++; printVerdict(); end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge clk);
      regAddr <= a; regWdata <= w; regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] x);
      @(posedge clk);
      regAddr <= a; regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRdata;
      `CHK(v, x)
   endtask
   task automatic printVerdict();
      if (numErrors == 0 && checksDone > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      chk(8'h0C, 32'h3);
      chk(8'hFC, 32'h0);
      wr(8'h14, 32'h1); wr(8'h24, 32'h100); wr(8'h28, 32'h3);
      wr(8'h1C, 32'h2); wr(8'h20, 32'h1);
      for (int i = 0; i < 3; i++) begin
         remote_uart_inst.grab(10, g);
         `CHK(g, {3'b001, 8'(i) ^ 8'h5A, 1'b0})
         if (i == 1) chk(8'h10, 32'h0);
         chk(8'h20, (i > 0) ? 32'h101 : 32'h1);
      end
      repeat (20) @(posedge clk);
      chk(8'h10, 32'h20);
      repeat (80) @(posedge clk);
      chk(8'h10, 32'h60);
      chk(8'h28, 32'h0);
      chk(8'h24, 32'h103); wr(8'h20, 32'h100);
      for (int i = 0; i < 8; i++) begin
         lc = (i == 0) ? 5'h1F : (i == 1) ? 5'h08 : lfsrReg[4:0];
         d = lfsrReg[12:5];
         wr(8'h0C, {27'h0, lc}); wr(8'h00, {24'h0, d});
         remote_uart_inst.grab(12, g);
         e = frame(d, lc, n);
         m = (12'h1 << n) - 12'h1;
         `CHK(g & m, e & m)
         repeat (80) @(posedge clk);
      end
      wr(8'h0C, 32'h3); wr(8'h2C, 32'h200); wr(8'h30, 32'h2);
      wr(8'h20, 32'h2);
      d = lfsrReg[7:0];
      remote_uart_inst.send(d);
      remote_uart_inst.send(~d);
      repeat (60) @(posedge clk);
      `CHK({wq[0], wq[1], aq[1]}, {d, ~d, 32'h201})
      `CHK(irq, 1'b0)
      wr(8'h04, 32'h20);
      repeat (4) @(posedge clk);
      `CHK(irq, 1'b1)
      chk(8'h08, 32'hC);
      wr(8'h04, 32'h0);
      repeat (4) @(posedge clk);
      `CHK(irq, 1'b0)
      printVerdict();
   end
endmodule
